/* absp_pkg.sv */
// Package for the audio/bulk serial input port: constants and carriers
package absp_pkg;

  // Bit clock divider: half period in system clock cycles
  localparam int unsigned SYS_CLK_HZ      = 50000000;
  localparam int unsigned BIT_CLK_HZ      = 2000000;
  localparam int unsigned HALF_DIV        = SYS_CLK_HZ / (2 * BIT_CLK_HZ);
  localparam logic [7:0]  HALF_DIV_LAST   = 8'(HALF_DIV - 1);

  // Audio frame: bits per channel slot
  localparam logic [4:0]  SLOT_BITS_LAST  = 5'h0f;
  localparam int unsigned SAMPLE_W        = 16;

  // Bulk FIFO geometry
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam int unsigned FIFO_AW         = 4;
  localparam logic [4:0]  FIFO_COUNT_FULL = 5'h10;

  // Pin outputs towards codec and bulk source
  typedef struct packed {
    logic bit_clock;
    logic left_frame_sync;
    logic right_frame_sync;
    logic bulk_fifo_full_flag;
  } absp_pins_t;

  // One finished audio sample
  typedef struct packed {
    logic                right;
    logic [SAMPLE_W-1:0] data;
  } absp_sample_t;

endpackage

/* absp_bulk_fifo.sv */
// Bit-wide bulk FIFO kept in flip-flops
`timescale 1ns/1ps
`default_nettype none
module absp_bulk_fifo (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Write side
  input  wire logic wr_valid,
  input  wire logic wr_bit,
  output logic      full,
  // Read side
  output logic      rd_valid,
  output logic      rd_bit,
  input  wire logic rd_ready
);
  import absp_pkg::*;

  logic [FIFO_DEPTH-1:0] mem_q;
  logic [FIFO_AW-1:0]    wp_q;
  logic [FIFO_AW-1:0]    rp_q;
  logic [FIFO_AW:0]      cnt_q;
  logic                  do_wr;
  logic                  do_rd;

  // Writes dropped when full so data is never overwritten
  assign full     = (cnt_q == FIFO_COUNT_FULL);
  assign rd_valid = (cnt_q != 5'h00);
  assign rd_bit   = mem_q[rp_q];
  assign do_wr    = wr_valid && !full;
  assign do_rd    = rd_valid && rd_ready;

  // Storage, one flop per entry
  genvar gi;
  generate
    for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_ent
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          mem_q[gi] <= 1'b0;
        end else if (do_wr && (wp_q == FIFO_AW'(gi))) begin
          mem_q[gi] <= wr_bit;
        end
      end
    end
  endgenerate

  // Pointers and fill count
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) begin
        wp_q <= wp_q + 4'h1;
      end
      if (do_rd) begin
        rp_q <= rp_q + 4'h1;
      end
      cnt_q <= cnt_q + (do_wr ? 5'h01 : 5'h00) - (do_rd ? 5'h01 : 5'h00);
    end
  end

endmodule
`default_nettype wire

/* absp_port.sv */
// Audio and bulk serial input port top level
// What this block does
// - The full flag is low normally and high whenever the bulk FIFO has no free space, except in suspend.
// - In suspend the full flag, both frame syncs and the bit clock are low.
// - With bulk enable high the data line is sampled into the FIFO at each bit clock fall while the FIFO has free space.
// - One data line carries codec and bulk bits; audio slots and bulk sampling are kept apart.
// - A left frame-sync pulse marks the start of each left-channel sample.
// - A right frame-sync pulse marks the start of each right-channel sample.
// - One bit clock output shifts both the codec and the bulk source.
`timescale 1ns/1ps
`default_nettype none
module absp_port (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // Power state
  input  wire logic                   suspend,
  // Pins from codec and bulk source
  input  wire logic                   bulk_data_enable,
  input  wire logic                   shared_serial_data_input,
  // Pins to codec and bulk source
  output absp_pkg::absp_pins_t        pins,
  // Captured audio samples
  output absp_pkg::absp_sample_t      sample,
  output logic                        sample_valid,
  // Bulk bit stream drained by the host side
  output logic                        bulk_valid,
  output logic                        bulk_bit,
  input  wire logic                   bulk_ready
);
  import absp_pkg::*;

  typedef enum logic [1:0] {ST_LEFT, ST_RIGHT} absp_slot_t;

  // Synchronisers for pin inputs
  logic [1:0] en_sync_q;
  logic [1:0] dat_sync_q;
  logic       susp_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      en_sync_q  <= 2'h0;
      dat_sync_q <= 2'h0;
      susp_q     <= 1'b0;
    end else begin
      en_sync_q  <= {en_sync_q[0], bulk_data_enable};
      dat_sync_q <= {dat_sync_q[0], shared_serial_data_input};
      susp_q     <= suspend;
    end
  end

  // Bit clock divider; halted in suspend so the pin stays low
  logic [7:0] div_q;
  logic       bclk_q;
  logic       fall_en;
  logic       rise_en;
  assign rise_en = !susp_q && (div_q == HALF_DIV_LAST) && !bclk_q;
  assign fall_en = !susp_q && (div_q == HALF_DIV_LAST) && bclk_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn || susp_q) begin
      div_q  <= 8'h00;
      bclk_q <= 1'b0;
    end else if (div_q == HALF_DIV_LAST) begin
      div_q  <= 8'h00;
      bclk_q <= !bclk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // Slot sequencer: counts bits of left then right sample
  absp_slot_t slot_q;
  logic [4:0] bit_q;
  logic       fsl_q;
  logic       fsr_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn || susp_q) begin
      slot_q <= ST_LEFT;
      bit_q  <= SLOT_BITS_LAST;
      fsl_q  <= 1'b0;
      fsr_q  <= 1'b0;
    end else if (rise_en) begin
      if (bit_q == SLOT_BITS_LAST) begin
        bit_q <= 5'h00;
        case (slot_q)
          ST_RIGHT: begin
            slot_q <= ST_LEFT;
            fsl_q  <= 1'b1;
          end
          ST_LEFT: begin
            slot_q <= ST_RIGHT;
            fsr_q  <= 1'b1;
          end
          default: slot_q <= ST_LEFT;
        endcase
      end else begin
        bit_q <= bit_q + 5'h01;
        fsl_q <= 1'b0;
        fsr_q <= 1'b0;
      end
    end
  end

  // Audio shift on falling edge, only when bulk is not enabled
  logic [SAMPLE_W-1:0] shift_q;
  absp_sample_t        sample_q;
  logic                svalid_q;
  logic                aud_take;
  assign aud_take = fall_en && !en_sync_q[1];
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      shift_q  <= '0;
      sample_q <= '0;
      svalid_q <= 1'b0;
    end else begin
      svalid_q <= 1'b0;
      if (aud_take) begin
        shift_q <= {shift_q[SAMPLE_W-2:0], dat_sync_q[1]};
        if (bit_q == SLOT_BITS_LAST) begin
          sample_q.data  <= {shift_q[SAMPLE_W-2:0], dat_sync_q[1]};
          sample_q.right <= (slot_q == ST_RIGHT);
          svalid_q       <= 1'b1;
        end
      end
    end
  end

  // Bulk capture into FIFO at falling bit clock edge
  logic bulk_wr;
  logic fifo_full;
  assign bulk_wr = fall_en && en_sync_q[1];
  absp_bulk_fifo u_fifo (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .wr_valid (bulk_wr),
    .wr_bit   (dat_sync_q[1]),
    .full     (fifo_full),
    .rd_valid (bulk_valid),
    .rd_bit   (bulk_bit),
    .rd_ready (bulk_ready)
  );

  // Registered pin outputs; suspend forces all low
  absp_pins_t pins_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pins_q <= '0;
    end else begin
      pins_q.bit_clock           <= bclk_q && !susp_q;
      pins_q.left_frame_sync     <= fsl_q && !susp_q;
      pins_q.right_frame_sync    <= fsr_q && !susp_q;
      pins_q.bulk_fifo_full_flag <= fifo_full && !susp_q;
    end
  end
  assign pins         = pins_q;
  assign sample       = sample_q;
  assign sample_valid = svalid_q;

  // Full flag follows the FIFO one cycle later
  full_flag_a : assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(susp_q) == 1'b0 |-> pins_q.bulk_fifo_full_flag == $past(fifo_full))
    else $error("full flag does not follow fifo");
  suspend_low_a : assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(susp_q) |-> (pins_q == '0))
    else $error("outputs not low in suspend");
  bulk_write_a : assert property (@(posedge clk_sys) disable iff (!rstn)
    bulk_wr |=> !bclk_q)
    else $error("bulk write off the falling edge");
  line_split_a : assert property (@(posedge clk_sys) disable iff (!rstn)
    !(bulk_wr && aud_take))
    else $error("line sampled by both streams");
  left_sync_a : assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(fsl_q) |-> slot_q == ST_LEFT && bit_q == 5'h00)
    else $error("left sync at wrong slot");
  right_sync_a : assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(fsr_q) |-> slot_q == ST_RIGHT && bit_q == 5'h00)
    else $error("right sync at wrong slot");
  bit_clock_a : assert property (@(posedge clk_sys) disable iff (!rstn || susp_q)
    rise_en |=> bclk_q [*2])
    else $error("bit clock half period short");
  no_overrun_a : assert property (@(posedge clk_sys) disable iff (!rstn)
    fifo_full && bulk_wr && !bulk_ready |=> fifo_full)
    else $error("full fifo lost its state");

endmodule
`default_nettype wire

/* absp_far_model.sv */
// Far-side model: telephony codec and bulk bit source on one data line
`timescale 1ns/1ps
`default_nettype none
module absp_far_model #(
  parameter logic [15:0] PAT = 16'hc35a
) (
  // Control from the bench
  input  wire logic                 bulk_go,
  // Pins from the device
  input  wire absp_pkg::absp_pins_t pins,
  // Pins to the device
  output logic                      en,
  output logic                      dat
);
  import absp_pkg::*;
  logic right_q = 1'b0;
  int   idx     = 0;
  // Enable starts low so the device never sees an unknown level
  logic en_q    = 1'b0;
  assign en = en_q;
  // Codec holds one level per slot: left all zero, right all one
  always @(posedge pins.left_frame_sync) right_q = 1'b0;
  always @(posedge pins.right_frame_sync) right_q = 1'b1;
  // Source moves on bit clock rise so the fall sees settled bits
  always @(posedge pins.bit_clock) begin
    en_q <= bulk_go && !pins.bulk_fifo_full_flag;
    if (en_q) idx <= idx + 1;
  end
  // Shared line: bulk bit while enabled, codec stream otherwise
  assign dat = en ? PAT[4'(15 - idx)] : right_q;
endmodule
`default_nettype wire

/* absp_port_tb_top.sv */
// Testbench for the audio and bulk serial input port
`timescale 1ns/1ps
`default_nettype none
module absp_port_tb_top;
  import absp_pkg::*;
  localparam logic [15:0] PAT = 16'hc35a;
  logic         clk_sys    = 1'b0;
  logic         rstn       = 1'b0;
  logic         suspend    = 1'b0;
  logic         bulk_go    = 1'b0;
  logic         bulk_ready = 1'b0;
  logic         en;
  logic         dat;
  logic         sample_valid;
  logic         bulk_valid;
  logic         bulk_bit;
  absp_pins_t   pins;
  absp_sample_t sample;
  int           num_errors = 0;
  int           tests_run  = 0;
  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;
  absp_far_model #(.PAT(PAT)) far (.bulk_go(bulk_go), .pins(pins), .en(en), .dat(dat));
  absp_port DUT (
    .clk_sys(clk_sys), .rstn(rstn), .suspend(suspend),
    .bulk_data_enable(en), .shared_serial_data_input(dat),
    .pins(pins), .sample(sample), .sample_valid(sample_valid),
    .bulk_valid(bulk_valid), .bulk_bit(bulk_bit), .bulk_ready(bulk_ready)
  );
  task automatic check(string name, logic [16:0] seen, logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Reset held 20 cycles; pins must be quiet
  task automatic test_reset();
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    check("pins_reset", 17'(pins), 17'h0);
    $display("end test_reset");
  endtask
  // Audio frames: bit clock rate and captured left and right slots
  task automatic test_audio();
    logic [16:0] l;
    logic [16:0] r;
    int          rises;
    int          nl;
    int          nr;
    logic        bc;
    rises = 0; nl = 0; nr = 0; bc = 1'b0; l = '1; r = '0;
    repeat (2000) begin
      @(negedge clk_sys);
      if (pins.bit_clock && !bc) rises++;
      bc = pins.bit_clock;
      if (sample_valid && sample.right) begin r = sample; nr++; end
      if (sample_valid && !sample.right) begin l = sample; nl++; end
    end
    check("bclk_rises", 17'(rises >= 82 && rises <= 84), 17'h1);
    check("left_seen", 17'(nl >= 2), 17'h1);
    check("right_seen", 17'(nr >= 2), 17'h1);
    check("left_data", l, {1'b0, 16'h0000});
    check("right_data", r, {1'b1, 16'hffff});
    $display("end test_audio");
  endtask
  // Bulk fill until the full flag rises, host side stalled
  task automatic test_fill();
    int n;
    n = 0;
    @(posedge clk_sys);
    bulk_go <= 1'b1;
    while (!pins.bulk_fifo_full_flag && n < 1500) begin @(negedge clk_sys); n++; end
    check("full_set", 17'(pins.bulk_fifo_full_flag), 17'h1);
    @(posedge clk_sys);
    bulk_go <= 1'b0;
    $display("end test_fill");
  endtask
  // Suspend forces every pin low
  task automatic test_suspend();
    logic [16:0] acc;
    acc = '0;
    @(posedge clk_sys);
    suspend <= 1'b1;
    repeat (5) @(posedge clk_sys);
    repeat (200) begin @(negedge clk_sys); acc |= 17'(pins); end
    check("pins_suspend", acc, 17'h0);
    @(posedge clk_sys);
    suspend <= 1'b0;
    $display("end test_suspend");
  endtask
  // Drain: bits come back first in first out, flag clears
  task automatic test_drain();
    logic [15:0] w;
    int          cnt;
    w = '0; cnt = 0;
    @(posedge clk_sys);
    bulk_ready <= 1'b1;
    repeat (600) begin
      @(negedge clk_sys);
      if (bulk_valid) begin w = {w[14:0], bulk_bit}; cnt++; end
    end
    check("bulk_count", 17'(cnt), 17'd16);
    check("bulk_bits", 17'(w), 17'(PAT));
    check("full_clear", 17'(pins.bulk_fifo_full_flag), 17'h0);
    @(posedge clk_sys);
    bulk_ready <= 1'b0;
    $display("end test_drain");
  endtask
  // Watchdog well past the expected run length
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    test_reset();
    test_audio();
    test_fill();
    test_suspend();
    test_drain();
    wrap_up();
  end
endmodule
`default_nettype wire
